// File: irq_map_pkg.sv
package irq_map_pkg;

   // -----------------------------------------------------------
   // Source select codes
   // -----------------------------------------------------------
   localparam logic [5:0] SEL_PACKET_FINISHED = 6'h08;
   localparam logic [5:0] SEL_TX_DONE = 6'h10;
   localparam logic [5:0] SEL_TXQ_NOT_FULL = 6'h11;
   localparam logic [5:0] SEL_TXQ_THRESHOLD = 6'h12;
   localparam logic [5:0] SEL_TXQ_FULL = 6'h13;
   localparam logic [5:0] SEL_RADIO_READY = 6'h14;
   localparam logic [5:0] SEL_RADIO_SYNTH = 6'h15;
   localparam logic [5:0] SEL_RADIO_RECEIVE = 6'h16;
   localparam logic [5:0] SEL_RADIO_TRANSMIT = 6'h17;
   localparam logic [5:0] SEL_LOW_SUPPLY = 6'h18;
   localparam logic [5:0] SEL_CMD_FAILED = 6'h19;
   localparam logic [5:0] SEL_CMD_COMPLETED = 6'h1A;
   localparam logic [5:0] SEL_DUTY_SEND_DONE = 6'h1B;
   localparam logic [5:0] SEL_ACK_MISSING = 6'h1C;
   localparam logic [5:0] SEL_REPEAT_SEND_DONE = 6'h1D;
   localparam logic [5:0] SEL_NACK_SEEN = 6'h1E;
   localparam logic [5:0] SEL_SEQUENCE_NUMBER_MATCH = 6'h1F;
   localparam logic [5:0] SEL_CS_ACCESS_DONE = 6'h20;
   localparam logic [5:0] SEL_CHANNEL_CLEAR = 6'h21;

   // -----------------------------------------------------------
   // Flag vector bit positions (host-cleared first)
   // -----------------------------------------------------------
   localparam int NUM_LATCHED = 12;
   localparam int NUM_LIVE = 7;
   localparam int NUM_SRC = 19;
   localparam int B_PACKET_FINISHED = 0;
   localparam int B_TX_DONE = 1;
   localparam int B_LOW_SUPPLY = 2;
   localparam int B_CMD_FAILED = 3;
   localparam int B_CMD_COMPLETED = 4;
   localparam int B_DUTY_SEND_DONE = 5;
   localparam int B_ACK_MISSING = 6;
   localparam int B_REPEAT_SEND_DONE = 7;
   localparam int B_NACK_SEEN = 8;
   localparam int B_SEQUENCE_NUMBER_MATCH = 9;
   localparam int B_CS_ACCESS_DONE = 10;
   localparam int B_CHANNEL_CLEAR = 11;
   localparam int B_TXQ_NOT_FULL = 12;
   localparam int B_TXQ_THRESHOLD = 13;
   localparam int B_TXQ_FULL = 14;
   localparam int B_RADIO_READY = 15;
   localparam int B_RADIO_SYNTH = 16;
   localparam int B_RADIO_RECEIVE = 17;
   localparam int B_RADIO_TRANSMIT = 18;

   // -----------------------------------------------------------
   // Register byte offsets
   // -----------------------------------------------------------
   localparam logic [7:0] OFS_FLAGS = 8'h00;
   localparam logic [7:0] OFS_CLEAR = 8'h04;
   localparam logic [7:0] OFS_CONTROL = 8'h08;
   localparam logic [7:0] OFS_MIX_ENABLE = 8'h0C;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

   // -----------------------------------------------------------
   // Control register layout and reset values
   // -----------------------------------------------------------
   localparam int CTL_FIRST_SEL_LSB = 0;
   localparam int CTL_SECOND_SEL_LSB = 8;
   localparam int CTL_POLARITY_BIT = 16;
   localparam int CTL_THIRD_PIN_BIT = 17;
   localparam logic [5:0] RST_SELECT = 6'h00;
   localparam logic [NUM_SRC-1:0] RST_MIX_ENABLE = 19'h00000;
   localparam logic [2:0] RST_IRQ_MASK = 3'h0;

   // Radio and supply events, all single-clock-domain pulses or levels
   typedef struct packed {
      logic channel_clear_result;
      logic carrier_sense_access_done;
      logic sequence_number_match;
      logic negative_acknowledge_seen;
      logic repeat_send_done;
      logic acknowledge_missing;
      logic duty_cycle_send_done;
      logic command_completed;
      logic command_failed;
      logic low_supply_detected;
      logic tx_done;
      logic packet_finished;
   } radio_events_s;

   typedef struct packed {
      logic radio_in_transmit;
      logic radio_in_receive;
      logic radio_in_synth;
      logic radio_in_ready;
      logic transmit_queue_full;
      logic transmit_queue_threshold;
      logic transmit_queue_not_full;
   } radio_levels_s;

   // Packet-finished causes
   typedef struct packed {
      logic conflict_wait;
      logic node_id_restart;
      logic manchester_restart;
      logic packet_correct;
   } packet_causes_s;

endpackage : irq_map_pkg

// File: radio_interrupt_source_mapper.sv
// Local design decisions: the address map and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none

// Function
// - Transmit queue not-full, above-threshold and full sources use codes 010001, 010010, 010011 and follow their live level.
// - Radio ready, synthesis, receive and transmit state sources use codes 010100 to 010111 and follow the live state.
// - Low supply detection, code 011000, latches when supply drops below threshold until the host clears it.
// - Command failure (011001) and command completion (011010) latch until the host clears them.
// - Duty-cycle send done (011011) and acknowledge missing (011100) latch until the host clears them.
// - Negative acknowledge seen (011110) and sequence match (011111) latch until the host clears them.
// - Repeat send done latches until host clear and takes the free code 011101 to avoid clashing with sequence match.
// - Carrier-sense access done (100000) and channel clear result (100001) latch until the host clears them.
// - First, second and third output pins are active high, or all active low when the polarity bit is one; irq_o is always active high.
// - First and second outputs each have an identical independent select path and each drives only its own fixed pin.
// - Third output carries only the mixed interrupt and may go only to pin 0 or pin 2.
// - Transmit done, code 010000, latches until the host clears it.
// - Packet finished, code 001000, latches on a correct packet, either auto-restart decode error, or a conflict.
module radio_interrupt_source_mapper
   import irq_map_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   input wire radio_events_s events_i,
   input wire packet_causes_s packet_causes_i,
   input wire radio_levels_s levels_i,
   output logic first_irq_output_o,
   output logic second_irq_output_o,
   output logic third_irq_pin0_o,
   output logic third_irq_pin2_o,
   output logic irq_o
);

   // -----------------------------------------------------------
   // Registers
   // -----------------------------------------------------------
   logic [NUM_LATCHED-1:0] latched_q;
   logic [NUM_LATCHED-1:0] latched_d;
   logic [5:0] first_output_source_select_q;
   logic [5:0] second_output_source_select_q;
   logic irq_output_polarity_q;
   logic third_pin_q;
   logic [NUM_SRC-1:0] mix_enable_q;
   logic [2:0] irq_status_q;
   logic [2:0] irq_status_d;
   logic [2:0] irq_mask_q;
   logic ack_q;
   logic [31:0] rdata_q;
   logic first_out_q;
   logic second_out_q;
   logic third_out_q;

   // -----------------------------------------------------------
   // Source collection
   // -----------------------------------------------------------
   wire logic [NUM_LATCHED-1:0] event_set;
   wire logic [NUM_SRC-1:0] flags;
   wire logic packet_event = |packet_causes_i;

   assign event_set = {events_i[NUM_LATCHED-1:1], events_i.packet_finished | packet_event};
   assign flags = {levels_i, latched_q};

   // -----------------------------------------------------------
   // Bus decode
   // -----------------------------------------------------------
   wire logic bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
   wire logic wr_req = bus_req & wb_we_i;
   wire logic rd_req = bus_req & ~wb_we_i;
   wire logic hit_flags = (wb_adr_i == OFS_FLAGS);
   wire logic hit_clear = (wb_adr_i == OFS_CLEAR);
   wire logic hit_ctl = (wb_adr_i == OFS_CONTROL);
   wire logic hit_mix = (wb_adr_i == OFS_MIX_ENABLE);
   wire logic hit_stat = (wb_adr_i == OFS_IRQ_STATUS);
   wire logic hit_mask = (wb_adr_i == OFS_IRQ_MASK);
   wire logic wr_ctl = wr_req & hit_ctl;
   wire logic wr_mix = wr_req & hit_mix;
   wire logic wr_mask = wr_req & hit_mask;
   wire logic [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire logic [31:0] wbits = wb_dat_i & wmask;
   wire logic [NUM_LATCHED-1:0] clear_bits = (wr_req & hit_clear) ?
      wbits[NUM_LATCHED-1:0] : '0;
   wire logic stat_read = rd_req & hit_stat;

   wire logic [31:0] ctl_view = {14'h0000, third_pin_q, irq_output_polarity_q,
      2'h0, second_output_source_select_q, 2'h0, first_output_source_select_q};
   wire logic [31:0] rd_mux =
      hit_flags ? {13'h0000, flags} :
      hit_ctl ? ctl_view :
      hit_mix ? {13'h0000, mix_enable_q} :
      hit_stat ? {29'h00000000, irq_status_q} :
      hit_mask ? {29'h00000000, irq_mask_q} : 32'h00000000;

   // Set wins over a clear in the same cycle so no event is lost
   assign latched_d = (latched_q & ~clear_bits) | event_set;

   // -----------------------------------------------------------
   // Source selection
   // -----------------------------------------------------------
   function automatic logic pick(input logic [5:0] sel, input logic [NUM_SRC-1:0] f);
      logic r;
      r = 1'b0;
      case (sel)
         SEL_PACKET_FINISHED: r = f[B_PACKET_FINISHED];
         SEL_TX_DONE: r = f[B_TX_DONE];
         SEL_TXQ_NOT_FULL: r = f[B_TXQ_NOT_FULL];
         SEL_TXQ_THRESHOLD: r = f[B_TXQ_THRESHOLD];
         SEL_TXQ_FULL: r = f[B_TXQ_FULL];
         SEL_RADIO_READY: r = f[B_RADIO_READY];
         SEL_RADIO_SYNTH: r = f[B_RADIO_SYNTH];
         SEL_RADIO_RECEIVE: r = f[B_RADIO_RECEIVE];
         SEL_RADIO_TRANSMIT: r = f[B_RADIO_TRANSMIT];
         SEL_LOW_SUPPLY: r = f[B_LOW_SUPPLY];
         SEL_CMD_FAILED: r = f[B_CMD_FAILED];
         SEL_CMD_COMPLETED: r = f[B_CMD_COMPLETED];
         SEL_DUTY_SEND_DONE: r = f[B_DUTY_SEND_DONE];
         SEL_ACK_MISSING: r = f[B_ACK_MISSING];
         SEL_REPEAT_SEND_DONE: r = f[B_REPEAT_SEND_DONE];
         SEL_NACK_SEEN: r = f[B_NACK_SEEN];
         SEL_SEQUENCE_NUMBER_MATCH: r = f[B_SEQUENCE_NUMBER_MATCH];
         SEL_CS_ACCESS_DONE: r = f[B_CS_ACCESS_DONE];
         SEL_CHANNEL_CLEAR: r = f[B_CHANNEL_CLEAR];
         default: r = 1'b0;
      endcase
      return r;
   endfunction : pick

   // Same selector for both outputs keeps their paths identical
   wire logic first_active = pick(first_output_source_select_q, flags);
   wire logic second_active = pick(second_output_source_select_q, flags);
   wire logic mix_active = |(flags & mix_enable_q);
   wire logic [2:0] irq_events = {mix_active & ~third_out_q,
      second_active & ~second_out_q, first_active & ~first_out_q};

   assign irq_status_d = (stat_read ? 3'h0 : irq_status_q) | irq_events;

   // -----------------------------------------------------------
   // State
   // -----------------------------------------------------------
   // Flags and interrupt status
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         latched_q <= '0;
         irq_status_q <= 3'h0;
      end else if (ce_i) begin
         latched_q <= latched_d;
         irq_status_q <= irq_status_d;
      end
   end

   // Outputs are registered so a select write never glitches a pin
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         first_out_q <= 1'b0;
         second_out_q <= 1'b0;
         third_out_q <= 1'b0;
      end else if (ce_i) begin
         first_out_q <= first_active;
         second_out_q <= second_active;
         third_out_q <= mix_active;
      end
   end

   // Read data stands only in the ack cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h00000000;
      end else if (ce_i) begin
         ack_q <= bus_req;
         rdata_q <= rd_req ? rd_mux : 32'h00000000;
      end
   end

   // Control lanes are written independently
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         first_output_source_select_q <= RST_SELECT;
         second_output_source_select_q <= RST_SELECT;
         irq_output_polarity_q <= 1'b0;
         third_pin_q <= 1'b0;
      end else if (ce_i) begin
         if (wr_ctl & wb_sel_i[0]) begin
            first_output_source_select_q <= wb_dat_i[CTL_FIRST_SEL_LSB +: 6];
         end
         if (wr_ctl & wb_sel_i[1]) begin
            second_output_source_select_q <= wb_dat_i[CTL_SECOND_SEL_LSB +: 6];
         end
         if (wr_ctl & wb_sel_i[2]) begin
            irq_output_polarity_q <= wb_dat_i[CTL_POLARITY_BIT];
            third_pin_q <= wb_dat_i[CTL_THIRD_PIN_BIT];
         end
      end
   end

   // Mixed enables and interrupt mask
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mix_enable_q <= RST_MIX_ENABLE;
         irq_mask_q <= RST_IRQ_MASK;
      end else if (ce_i) begin
         if (wr_mix) begin
            mix_enable_q <= (mix_enable_q & ~wmask[NUM_SRC-1:0]) | wbits[NUM_SRC-1:0];
         end
         if (wr_mask & wb_sel_i[0]) begin
            irq_mask_q <= wb_dat_i[2:0];
         end
      end
   end

   // -----------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------
   // Polarity is applied after the flop, so a polarity write acts at once
   assign first_irq_output_o = first_out_q ^ irq_output_polarity_q;
   assign second_irq_output_o = second_out_q ^ irq_output_polarity_q;
   // Unused third-output pin sits at its inactive level
   assign third_irq_pin0_o = (third_out_q & ~third_pin_q) ^ irq_output_polarity_q;
   assign third_irq_pin2_o = (third_out_q & third_pin_q) ^ irq_output_polarity_q;
   assign irq_o = |(irq_status_q & irq_mask_q);
   assign wb_ack_o = ack_q & wb_cyc_i & wb_stb_i;
   assign wb_err_o = 1'b0;
   // Straight from the flop; unmapped reads already load zero
   assign wb_dat_o = rdata_q;

   // -----------------------------------------------------------
   // Checks
   // -----------------------------------------------------------
   latched_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && $past(ce_i) && !$past(rst_i) && $past(latched_q[B_LOW_SUPPLY])
      && !$past(clear_bits[B_LOW_SUPPLY])
      |-> latched_q[B_LOW_SUPPLY]) else $error("Low supply flag dropped without clear");

   latched_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && events_i.low_supply_detected |=> latched_q[B_LOW_SUPPLY])
      else $error("Low supply event not latched");

   cmd_flags_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && (events_i.command_failed || events_i.command_completed)
      |=> (latched_q[B_CMD_FAILED] || !$past(events_i.command_failed))
      && (latched_q[B_CMD_COMPLETED] || !$past(events_i.command_completed)))
      else $error("Command flags not latched");

   packet_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && packet_causes_i.conflict_wait |=> latched_q[B_PACKET_FINISHED])
      else $error("Packet finished not set on conflict");

   live_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
      flags[B_TXQ_FULL] == levels_i.transmit_queue_full)
      else $error("Live queue source not following level");

   first_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && first_output_source_select_q == SEL_RADIO_RECEIVE && $stable(first_output_source_select_q)
      && levels_i.radio_in_receive |=> first_out_q) else $error("Receive state not routed");

   resend_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && second_output_source_select_q == SEL_REPEAT_SEND_DONE
      |-> second_active == latched_q[B_REPEAT_SEND_DONE]) else $error("Repeat send code wrong");

   polarity_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !first_out_q |-> first_irq_output_o == irq_output_polarity_q)
      else $error("Idle output level wrong for polarity");

   third_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && $past(ce_i) && !$past(rst_i) && $past(mix_active) && !third_pin_q
      |-> third_irq_pin0_o != irq_output_polarity_q) else $error("Mixed interrupt missing on pin 0");

   mix_or_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && (flags & mix_enable_q) == '0 |=> !third_out_q || !$past(ce_i))
      else $error("Mixed output high with nothing enabled");

   ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && wb_ack_o |=> !wb_ack_o) else $error("Bus ack held past one cycle");

   txq_full_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && first_output_source_select_q == SEL_TXQ_FULL
      |=> first_out_q == $past(levels_i.transmit_queue_full))
      else $error("Queue full level not routed");

   ready_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && second_output_source_select_q == SEL_RADIO_READY
      |=> second_out_q == $past(levels_i.radio_in_ready))
      else $error("Ready state not routed");

   ack_missing_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && events_i.acknowledge_missing |=> latched_q[B_ACK_MISSING])
      else $error("Ack missing flag not latched");

   nack_seen_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && events_i.negative_acknowledge_seen |=> latched_q[B_NACK_SEEN])
      else $error("Nack flag not latched");

   channel_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && events_i.channel_clear_result |=> latched_q[B_CHANNEL_CLEAR])
      else $error("Channel clear flag not latched");

   tx_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && events_i.tx_done |=> latched_q[B_TX_DONE])
      else $error("Transmit done flag not latched");

   manchester_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && packet_causes_i.manchester_restart |=> latched_q[B_PACKET_FINISHED])
      else $error("Packet finished not set on decode restart");

   clear_drops_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && clear_bits[B_CMD_FAILED] && !events_i.command_failed
      |=> !latched_q[B_CMD_FAILED]) else $error("Clear write did not drop flag");

   second_path_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && second_output_source_select_q == first_output_source_select_q
      |=> second_out_q == first_out_q) else $error("Output paths differ");

   third_mix_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i |=> third_out_q == $past(mix_active)) else $error("Third output not from mix");

   pin2_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !third_pin_q |-> third_irq_pin2_o == irq_output_polarity_q)
      else $error("Unused pin 2 not idle");

   cmd_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && first_output_source_select_q == SEL_CMD_COMPLETED
      |=> first_out_q == $past(latched_q[B_CMD_COMPLETED]))
      else $error("Completion flag not routed");

   polarity_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
      irq_output_polarity_q && first_out_q |-> !first_irq_output_o)
      else $error("Active output not low under inverted polarity");

   status_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && first_active && !first_out_q |=> irq_status_q[0])
      else $error("Status not set on first output rise");

endmodule : radio_interrupt_source_mapper

`default_nettype wire

// File: irq_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// -----------------------------------------------------------
// Host side of the interrupt pins
// -----------------------------------------------------------
// Software knows the polarity it programmed, so it reads a pin as "source active"
// through that setting; the raw pin level alone would mislead it
module irq_host_model (
   input wire logic polarity_i,
   input wire logic first_pin_i,
   input wire logic second_pin_i,
   input wire logic third_pin0_i,
   input wire logic third_pin2_i,
   output logic first_active_o,
   output logic second_active_o,
   output logic third0_active_o,
   output logic third2_active_o
);
   assign first_active_o = first_pin_i ^ polarity_i;
   assign second_active_o = second_pin_i ^ polarity_i;
   assign third0_active_o = third_pin0_i ^ polarity_i;
   assign third2_active_o = third_pin2_i ^ polarity_i;
endmodule : irq_host_model
`default_nettype wire

// File: test_radio_interrupt_source_mapper.sv
`timescale 1ns/100ps
`default_nettype none
module test_radio_interrupt_source_mapper
   import irq_map_pkg::*;
;
   logic clk_i, rst_i, cyc, stb, we, ack, err, irq, pol, ce;
   logic [3:0] sel;
   logic p1, p2, p30, p32, a1, a2, a30, a32;
   logic [7:0] adr;
   logic [31:0] wdat, rdat, seed, ctl;
   logic [5:0] other;
   logic [3:0] exp_pins;
   radio_events_s ev;
   packet_causes_s pc;
   radio_levels_s lv;
   int err_count, check_count;
   logic [31:0] expq[$];
   // Codes indexed by flag bit position
   logic [5:0] code_tab [0:18] = '{6'h08, 6'h10, 6'h18, 6'h19, 6'h1A, 6'h1B, 6'h1C, 6'h1D,
      6'h1E, 6'h1F, 6'h20, 6'h21, 6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h17};

   radio_interrupt_source_mapper dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .events_i(ev),
      .packet_causes_i(pc), .levels_i(lv), .first_irq_output_o(p1),
      .second_irq_output_o(p2), .third_irq_pin0_o(p30), .third_irq_pin2_o(p32), .irq_o(irq));
   irq_host_model host (.polarity_i(pol), .first_pin_i(p1), .second_pin_i(p2),
      .third_pin0_i(p30), .third_pin2_i(p32), .first_active_o(a1), .second_active_o(a2),
      .third0_active_o(a30), .third2_active_o(a32));

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   // -----------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   task automatic end_sim();
      $display("counts: %0d checks, %0d mismatches", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_sim

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : cmp

   // Slave latency is not assumed; the wait ends on ack or after the 20-cycle bound
   task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'hF;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) begin
         err_count++;
         $display("mismatch at %0t: bus answer never came", $time);
         end_sim();
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      sel <= 4'h0;
      @(posedge clk_i);
   endtask : wb_cycle

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      expq.push_back(exp);
      wb_cycle(1'b0, a, 32'h0);
   endtask : rd

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask : tick

   task automatic pins(input logic [3:0] e);
      cmp({28'h0, a1, a2, a30, a32}, {28'h0, e}, "pins");
   endtask : pins

   // Read data is judged as it appears, against the oldest note
   always @(posedge clk_i) begin
      if (ack === 1'b1) cmp({31'h0, err}, 32'h0, "bus error");
      if (ack === 1'b1 && cyc && !we) begin
         if (expq.size() > 0) cmp(rdat, expq.pop_front(), "read data");
         else cmp(rdat, 32'hFFFFFFFF, "unexpected read");
      end
   end

   // -----------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------
   initial begin
      err_count = 0;
      check_count = 0;
      seed = 32'h0000D6EE;
      {cyc, stb, we, pol, adr, wdat, sel} = '0;
      ce = 1'b1;
      ev = '0;
      pc = '0;
      lv = '0;
      rst_i = 1'b1;
      tick(20);
      rst_i <= 1'b0;
      tick(1);
      rd(OFS_FLAGS, 32'h0);
      rd(OFS_CONTROL, 32'h0);
      rd(OFS_MIX_ENABLE, 32'h0);
      rd(OFS_IRQ_MASK, 32'h0);
      rd(OFS_CLEAR, 32'h0);
      rd(8'h18, 32'h0);
      pins(4'h0);
      $display("test reset values done");
      // Even bits go through the first path, odd bits through the second
      for (int b = 0; b < 19; b++) begin
         other = 6'h22 + 6'(xs() % 30);
         ctl = (b % 2 == 0) ? {18'h0, other, 2'h0, code_tab[b]} : {18'h0, code_tab[b], 2'h0, other};
         exp_pins = (b % 2 == 0) ? 4'b1000 : 4'b0100;
         wb_cycle(1'b1, OFS_CONTROL, ctl);
         if (b == 0) pc[2'(xs())] <= 1'b1;
         else if (b < 12) ev[b] <= 1'b1;
         else lv[b - 12] <= 1'b1;
         tick(1);
         pc <= '0;
         ev <= '0;
         tick(4);
         pins(exp_pins);
         rd(OFS_FLAGS, 32'h1 << b);
         if (b < 12) begin
            pins(exp_pins);
            wb_cycle(1'b1, OFS_CLEAR, 32'h1 << b);
         end else lv <= '0;
         tick(4);
         pins(4'h0);
         rd(OFS_FLAGS, 32'h0);
      end
      $display("test source select paths done");
      wb_cycle(1'b1, OFS_CONTROL, 32'h8);
      for (int c = 0; c < 4; c++) begin
         pc[c] <= 1'b1;
         tick(1);
         pc <= '0;
         tick(4);
         pins(4'b1000);
         wb_cycle(1'b1, OFS_CLEAR, 32'h1);
         tick(4);
         pins(4'h0);
      end
      rd(OFS_IRQ_STATUS, 32'h3);
      $display("test packet causes done");
      // Mixed line enabled for command failure only
      wb_cycle(1'b1, OFS_CONTROL, 32'h0);
      wb_cycle(1'b1, OFS_MIX_ENABLE, 32'h8);
      ev[4] <= 1'b1;
      tick(1);
      ev <= '0;
      tick(4);
      pins(4'h0);
      ev[3] <= 1'b1;
      tick(1);
      ev <= '0;
      tick(4);
      pins(4'b0010);
      cmp({31'h0, irq}, 32'h0, "masked irq");
      wb_cycle(1'b1, OFS_CONTROL, 32'h20000);
      tick(3);
      pins(4'b0001);
      wb_cycle(1'b1, OFS_IRQ_MASK, 32'h4);
      tick(3);
      cmp({31'h0, irq}, 32'h1, "unmasked irq");
      rd(OFS_IRQ_STATUS, 32'h4);
      tick(3);
      cmp({31'h0, irq}, 32'h0, "irq after status read");
      wb_cycle(1'b1, OFS_CLEAR, 32'hFFF);
      tick(4);
      pins(4'h0);
      // A pulse while the clock enable is low is not seen
      ce <= 1'b0;
      ev[5] <= 1'b1;
      tick(1);
      ev <= '0;
      ce <= 1'b1;
      tick(2);
      rd(OFS_FLAGS, 32'h0);
      $display("test mixed line and interrupt done");
      wb_cycle(1'b1, OFS_CONTROL, 32'h10014);
      pol <= 1'b1;
      tick(3);
      cmp({28'h0, p1, p2, p30, p32}, 32'hF, "inverted idle pins");
      pins(4'h0);
      lv[3] <= 1'b1;
      tick(3);
      cmp({28'h0, p1, p2, p30, p32}, 32'h7, "active low pin");
      pins(4'b1000);
      $display("test polarity done");
      end_sim();
   end
endmodule : test_radio_interrupt_source_mapper
`default_nettype wire
